// *** rtl/escc_map.svh ***
// Register offsets, field positions, reset values and framing counts of the code controller
`ifndef ESCC_MAP_SVH
`define ESCC_MAP_SVH
`define ESCC_ADDR_W 12
`define ESCC_OFF_CTRL 12'h170
`define ESCC_OFF_HIST 12'h171
`define ESCC_OFF_EXP1 12'h172
`define ESCC_OFF_EXP2 12'h173
`define ESCC_OFF_EXP3 12'h174
`define ESCC_OFF_TXCODE 12'h175
`define ESCC_OFF_TXRPT 12'h176
`define ESCC_CTRL_SRC 7
`define ESCC_CTRL_MF_HI 6
`define ESCC_CTRL_MF_LO 5
`define ESCC_CTRL_RXEN 4
`define ESCC_CTRL_RST 3
`define ESCC_CTRL_RF_HI 2
`define ESCC_CTRL_RF_LO 1
`define ESCC_CTRL_SEND 0
`define ESCC_RST_BYTE 8'h00
`define ESCC_RST_CODE 4'h0
`define ESCC_RST_FSEL 2'h0
`define ESCC_RST_RPT 8'h01
`define ESCC_FIRST_FRAME 4'h2
`define ESCC_CODE_BITS 3'h4
`define ESCC_FLT_N0 3'h1
`define ESCC_FLT_N1 3'h3
`define ESCC_FLT_N2 3'h5
`define ESCC_FLT_N3 3'h7
`define ESCC_RUN_MAX 3'h7
`define ESCC_CRC_CFG_BAD 2'h3
`endif

// *** rtl/escc_pkg.sv ***
// Types shared by the code controller modules
package escc_pkg;
    typedef logic [3:0] escc_code_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_WAIT = 2'b01,
        TX_SEND = 2'b10,
        TX_ONES = 2'b11
    } escc_tx_st_t;
    typedef enum logic [3:0] {
        QL_UNKNOWN = 4'h0,
        QL_PRC = 4'h2,
        QL_SSUA = 4'h4,
        QL_SSUB = 4'h8,
        QL_SEC = 4'hB,
        QL_DNU = 4'hF
    } escc_ql_t;
endpackage

// *** rtl/escc_flt_if.sv ***
// Link between the controller and one consecutive-code filter
`timescale 1ns/1ps
interface escc_flt_if;
    logic load;
    logic [3:0] code;
    logic [1:0] sel;
    logic pass;
    modport ctl (output load, output code, output sel, input pass);
    modport flt (input load, input code, input sel, output pass);
endinterface

// *** rtl/escc_code_filter.sv ***
// Consecutive identical code qualifier
`timescale 1ns/1ps
`include "escc_map.svh"
module escc_code_filter
    import escc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic clr_i,
    // Code stream
    escc_flt_if.flt f
);
    function automatic logic [2:0] need(input logic [1:0] sel);
        unique case (sel)
            2'b00: need = `ESCC_FLT_N0;
            2'b01: need = `ESCC_FLT_N1;
            2'b10: need = `ESCC_FLT_N2;
            2'b11: need = `ESCC_FLT_N3;
        endcase
    endfunction

    logic [3:0] last_q;
    logic [2:0] run_q;
    logic [2:0] run_d;
    logic pass_q;

    always_comb
    begin
        if (run_q != 3'h0 && f.code == last_q)
            run_d = (run_q == `ESCC_RUN_MAX) ? run_q : run_q + 3'h1;
        else
            run_d = 3'h1;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            last_q <= 4'h0;
            run_q <= 3'h0;
            pass_q <= 1'b0;
        end
        else if (ce_i)
        begin
            pass_q <= 1'b0;
            if (clr_i)
            begin
                last_q <= 4'h0;
                run_q <= 3'h0;
            end
            else if (f.load)
            begin
                last_q <= f.code;
                run_q <= run_d;
                pass_q <= (f.sel == 2'b00) || (run_d == need(f.sel) && run_d != run_q);
            end
        end
    end

    assign f.pass = pass_q;

    filter_pass_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        ce_i && f.load && !clr_i && run_d == need(f.sel) && run_d != run_q |=>
        pass_q && run_q == need($past(f.sel)))
        else $error("filter pass missing at threshold");

    filter_none_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        ce_i && f.load && !clr_i && f.sel == 2'b00 |=> pass_q)
        else $error("unfiltered code did not pass");

    filter_once_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        ce_i && f.load && !clr_i && f.sel != 2'b00 && run_d == run_q |=> !pass_q)
        else $error("saturated run passed again");
endmodule

// *** rtl/escc_code_ctrl.sv ***
// E1 sync status code controller: register port, code insertion and extraction
// Summary of operation
// - Send code MSB first from frame 2, one bit per qualifying frame.
// - Codes are 4 bits; known quality levels listed, others reserved.
// - Source-select bit picks Sa (0, default) or Si (1) both ways.
// - Active code bits override ordinary Sa values in that position.
// - Match filter needs 0, 3, 5 or 7 identical codes before match events.
// - Receiver monitors carrier only while receive-enable is one.
// - Controller-reset bit restores registers to defaults and self-clears.
// - Receive filter needs 0, 3, 5 or 7 identical codes before update.
// - Send bit starts transmission of stored code and self-clears.
// - Validated code goes to bits 3:0, prior code moves to 7:4.
// - Three expected-code registers each raise their own filtered match event.
// - Change-of-status event when validated code differs from stored one.
// - Transmitter inserts stored code automatically once send is requested.
// - Repeat count sets sends before all-ones; one default, zero continuous.
// - With Si carrier, code bits take precedence over programmed Si values.
`timescale 1ns/1ps
`include "escc_map.svh"
module escc_code_ctrl
    import escc_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Framer overhead timing
    input wire logic oh_slot_i,
    input wire logic [3:0] oh_frame_i,
    // Framer carrier configuration
    input wire logic [4:0] sa_pos_sel_i,
    input wire logic crc_mf_en_i,
    input wire logic [1:0] crc_multiframe_cfg_i,
    // Received overhead bits
    input wire logic [4:0] rx_sa_i,
    input wire logic rx_si_i,
    // Transmit overhead bits
    output logic [4:0] tx_sa_o,
    output logic [4:0] tx_sa_ovr_o,
    output logic tx_si_o,
    output logic tx_si_ovr_o,
    // Events and status
    output logic rx_status_alarm_o,
    output logic cos_evt_o,
    output logic [2:0] match_evt_o,
    output logic tx_done_evt_o,
    output logic rx_code_rsvd_o,
    output logic cfg_err_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Register port decode

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    function automatic logic known_code(input escc_code_t c);
        unique case (c)
            QL_UNKNOWN, QL_PRC, QL_SSUA, QL_SSUB, QL_SEC, QL_DNU: known_code = 1'b1;
            default: known_code = 1'b0;
        endcase
    endfunction

    logic wr;
    logic wr_ctrl;
    logic clr;
    logic send;
    assign wr = ce_i && reg_wr_i;
    assign wr_ctrl = wr && hit(reg_addr_i, `ESCC_OFF_CTRL);
    assign clr = wr_ctrl && reg_wdata_i[`ESCC_CTRL_RST];
    assign send = wr_ctrl && reg_wdata_i[`ESCC_CTRL_SEND] && !clr;

    logic carrier_select_q;
    logic [1:0] match_filter_sel_q;
    logic rx_code_enable_q;
    logic [1:0] rx_code_filter_sel_q;
    escc_code_t exp_q [3];
    escc_code_t tx_code_field_q;
    logic [7:0] tx_repeat_count_q;

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            carrier_select_q <= 1'b0;
            match_filter_sel_q <= `ESCC_RST_FSEL;
            rx_code_enable_q <= 1'b0;
            rx_code_filter_sel_q <= `ESCC_RST_FSEL;
            tx_code_field_q <= `ESCC_RST_CODE;
            tx_repeat_count_q <= `ESCC_RST_RPT;
            for (int i = 0; i < 3; i++)
                exp_q[i] <= `ESCC_RST_CODE;
        end
        else if (clr)
        begin
            carrier_select_q <= 1'b0;
            match_filter_sel_q <= `ESCC_RST_FSEL;
            rx_code_enable_q <= 1'b0;
            rx_code_filter_sel_q <= `ESCC_RST_FSEL;
            tx_code_field_q <= `ESCC_RST_CODE;
            tx_repeat_count_q <= `ESCC_RST_RPT;
            for (int i = 0; i < 3; i++)
                exp_q[i] <= `ESCC_RST_CODE;
        end
        else if (wr)
        begin
            if (wr_ctrl)
            begin
                carrier_select_q <= reg_wdata_i[`ESCC_CTRL_SRC];
                match_filter_sel_q <= reg_wdata_i[`ESCC_CTRL_MF_HI:`ESCC_CTRL_MF_LO];
                rx_code_enable_q <= reg_wdata_i[`ESCC_CTRL_RXEN];
                rx_code_filter_sel_q <= reg_wdata_i[`ESCC_CTRL_RF_HI:`ESCC_CTRL_RF_LO];
            end
            if (hit(reg_addr_i, `ESCC_OFF_EXP1))
                exp_q[0] <= reg_wdata_i[3:0];
            if (hit(reg_addr_i, `ESCC_OFF_EXP2))
                exp_q[1] <= reg_wdata_i[3:0];
            if (hit(reg_addr_i, `ESCC_OFF_EXP3))
                exp_q[2] <= reg_wdata_i[3:0];
            if (hit(reg_addr_i, `ESCC_OFF_TXCODE))
                tx_code_field_q <= reg_wdata_i[3:0];
            if (hit(reg_addr_i, `ESCC_OFF_TXRPT))
                tx_repeat_count_q <= reg_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Multiframe code slot position

    logic [2:0] idx_q;
    logic pre_slot;
    logic code_slot;
    logic code_last;
    // code window opens at frame 2
    assign pre_slot = oh_slot_i && (oh_frame_i < `ESCC_FIRST_FRAME);
    assign code_slot = oh_slot_i && !pre_slot && (idx_q < `ESCC_CODE_BITS);
    assign code_last = code_slot && (idx_q == `ESCC_CODE_BITS - 3'h1);

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            idx_q <= `ESCC_CODE_BITS;
        else if (ce_i)
        begin
            if (pre_slot)
                idx_q <= 3'h0;
            else if (code_slot)
                idx_q <= idx_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmitter

    escc_tx_st_t st_q;
    escc_code_t tx_cur_q;
    logic [7:0] rpt_left_q;
    logic tx_done_q;
    logic tx_bit;
    logic tx_ovr;

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_q <= TX_IDLE;
            tx_cur_q <= `ESCC_RST_CODE;
            rpt_left_q <= `ESCC_RST_RPT;
            tx_done_q <= 1'b0;
        end
        else if (ce_i)
        begin
            tx_done_q <= 1'b0;
            if (clr)
                st_q <= TX_IDLE;
            // code latched and sent with no further action
            else if (send)
            begin
                st_q <= TX_WAIT;
                tx_cur_q <= tx_code_field_q;
                rpt_left_q <= tx_repeat_count_q;
            end
            else
            begin
                unique case (st_q)
                    TX_IDLE: st_q <= TX_IDLE;
                    TX_WAIT:
                        if (pre_slot)
                            st_q <= TX_SEND;
                    TX_SEND:
                        if (code_last && rpt_left_q != 8'h00)
                        begin
                            rpt_left_q <= rpt_left_q - 8'h01;
                            if (rpt_left_q == 8'h01)
                                st_q <= TX_ONES;
                        end
                    TX_ONES:
                        if (code_last)
                        begin
                            st_q <= TX_IDLE;
                            tx_done_q <= 1'b1;
                        end
                endcase
            end
        end
    end

    assign tx_bit = (st_q == TX_ONES) ? 1'b1 : tx_cur_q[2'd3 - idx_q[1:0]];
    assign tx_ovr = code_slot && (st_q == TX_SEND || st_q == TX_ONES);
    // override of the chosen Sa position
    assign tx_sa_ovr_o = (tx_ovr && !carrier_select_q) ? sa_pos_sel_i : 5'h00;
    assign tx_sa_o = {5{tx_bit}} & sa_pos_sel_i;
    assign tx_si_ovr_o = tx_ovr && carrier_select_q;
    assign tx_si_o = tx_bit;
    assign tx_done_evt_o = tx_done_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver

    escc_flt_if rf ();
    escc_flt_if mf ();
    logic rx_bit;
    escc_code_t rx_sh_q;
    escc_code_t rx_code_q;
    logic rx_load_q;
    escc_code_t prior_rx_code_q;
    escc_code_t latest_rx_code_q;
    logic alarm_q;
    logic cos_q;
    logic [2:0] match_q;

    // receive carrier follows the select bit
    assign rx_bit = carrier_select_q ? rx_si_i : |(rx_sa_i & sa_pos_sel_i);

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rx_sh_q <= `ESCC_RST_CODE;
            rx_code_q <= `ESCC_RST_CODE;
            rx_load_q <= 1'b0;
        end
        else if (ce_i)
        begin
            rx_load_q <= 1'b0;
            if (code_slot && rx_code_enable_q && !clr)
            begin
                rx_sh_q <= {rx_sh_q[2:0], rx_bit};
                if (code_last)
                begin
                    rx_code_q <= {rx_sh_q[2:0], rx_bit};
                    rx_load_q <= 1'b1;
                end
            end
        end
    end

    assign rf.load = rx_load_q;
    assign rf.code = rx_code_q;
    assign rf.sel = rx_code_filter_sel_q;
    assign mf.load = rx_load_q;
    assign mf.code = rx_code_q;
    assign mf.sel = match_filter_sel_q;

    escc_code_filter u_rx_flt (
        .ref_clk_i (ref_clk_i),
        .nrst_i (nrst_i),
        .ce_i (ce_i),
        .clr_i (clr || !rx_code_enable_q),
        .f (rf)
    );

    // match filter shared by all three matches
    escc_code_filter u_match_flt (
        .ref_clk_i (ref_clk_i),
        .nrst_i (nrst_i),
        .ce_i (ce_i),
        .clr_i (clr || !rx_code_enable_q),
        .f (mf)
    );

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            prior_rx_code_q <= `ESCC_RST_CODE;
            latest_rx_code_q <= `ESCC_RST_CODE;
            alarm_q <= 1'b0;
            cos_q <= 1'b0;
        end
        else if (ce_i)
        begin
            alarm_q <= 1'b0;
            cos_q <= 1'b0;
            if (clr)
            begin
                prior_rx_code_q <= `ESCC_RST_CODE;
                latest_rx_code_q <= `ESCC_RST_CODE;
            end
            else if (rf.pass)
            begin
                prior_rx_code_q <= latest_rx_code_q;
                latest_rx_code_q <= rx_code_q;
                alarm_q <= 1'b1;
                cos_q <= (rx_code_q != latest_rx_code_q);
            end
        end
    end

    // one match event per expected code
    for (genvar k = 0; k < 3; k++)
    begin : g_match
        always_ff @(posedge ref_clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
                match_q[k] <= 1'b0;
            else if (ce_i)
                match_q[k] <= mf.pass && !clr && (rx_code_q == exp_q[k]);
        end
    end

    assign rx_status_alarm_o = alarm_q;
    assign cos_evt_o = cos_q;
    assign match_evt_o = match_q;
    assign rx_code_rsvd_o = !known_code(latest_rx_code_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration check and read data

    logic cfg_err_q;
    logic [7:0] rdata_q;

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cfg_err_q <= 1'b0;
        else if (ce_i)
        begin
            if (carrier_select_q)
                cfg_err_q <= !crc_mf_en_i || crc_multiframe_cfg_i == `ESCC_CRC_CFG_BAD;
            else
                cfg_err_q <= sa_pos_sel_i == 5'h00 || (sa_pos_sel_i & (sa_pos_sel_i - 5'h01)) != 5'h00;
        end
    end

    assign cfg_err_o = cfg_err_q;

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_q <= `ESCC_RST_BYTE;
        else if (ce_i && reg_rd_i)
        begin
            unique case (reg_addr_i)
                // send and reset bits read back as zero
                `ESCC_OFF_CTRL: rdata_q <= {carrier_select_q, match_filter_sel_q,
                    rx_code_enable_q, 1'b0, rx_code_filter_sel_q, 1'b0};
                `ESCC_OFF_HIST: rdata_q <= {prior_rx_code_q, latest_rx_code_q};
                `ESCC_OFF_EXP1: rdata_q <= {4'h0, exp_q[0]};
                `ESCC_OFF_EXP2: rdata_q <= {4'h0, exp_q[1]};
                `ESCC_OFF_EXP3: rdata_q <= {4'h0, exp_q[2]};
                `ESCC_OFF_TXCODE: rdata_q <= {4'h0, tx_code_field_q};
                `ESCC_OFF_TXRPT: rdata_q <= tx_repeat_count_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_send_req;
        send;
    endsequence

    sequence s_mf_open;
        ce_i && pre_slot;
    endsequence

    send_start_a: assert property (s_send_req |=> st_q == TX_WAIT && tx_cur_q == $past(tx_code_field_q))
        else $error("send did not start transmission");

    wait_frame2_a: assert property (st_q == TX_WAIT && !send && !clr ##0 s_mf_open |=>
        st_q == TX_SEND && idx_q == 3'h0)
        else $error("code did not start at frame 2");

    tx_msb_a: assert property (st_q == TX_SEND && code_slot && idx_q == 3'h0 |->
        tx_bit == tx_cur_q[3])
        else $error("first code bit is not the MSB");

    sa_override_a: assert property (tx_ovr && !carrier_select_q |-> tx_sa_ovr_o == sa_pos_sel_i
        && !tx_si_ovr_o)
        else $error("Sa override wrong");

    si_priority_a: assert property (tx_ovr && carrier_select_q |-> tx_si_ovr_o
        && tx_sa_ovr_o == 5'h00)
        else $error("Si override missing");

    repeat_cont_a: assert property (ce_i && st_q == TX_SEND && rpt_left_q == 8'h00 && code_last
        && !send && !clr |=> st_q == TX_SEND)
        else $error("continuous send stopped");

    rx_enable_a: assert property (rx_load_q |-> $past(rx_code_enable_q))
        else $error("code loaded while receiver disabled");

    hist_shift_a: assert property (ce_i && rf.pass && !clr |=>
        latest_rx_code_q == $past(rx_code_q) && prior_rx_code_q == $past(latest_rx_code_q))
        else $error("history shift wrong");

    cos_event_a: assert property (ce_i && rf.pass && !clr |=>
        cos_q == ($past(rx_code_q) != $past(latest_rx_code_q)) && alarm_q)
        else $error("change of status wrong");

    match_event_a: assert property (ce_i && mf.pass && !clr && rx_code_q == exp_q[1] |=>
        match_q[1])
        else $error("match event missing");

    ctrl_reset_a: assert property (clr |=> st_q == TX_IDLE && tx_repeat_count_q == `ESCC_RST_RPT
        && !carrier_select_q && latest_rx_code_q == `ESCC_RST_CODE)
        else $error("controller reset incomplete");
endmodule

// *** sim/escc_remote_model.sv ***
// Remote terminal and framer slot timing model for the code controller
`timescale 1ns/1ps
module escc_remote_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Code sent by the remote terminal
    input wire logic [3:0] code_i,
    // Slot timing and received bits
    output logic oh_slot_o,
    output logic [3:0] oh_frame_o,
    output logic [4:0] rx_sa_o,
    output logic rx_si_o,
    // Bits from the device
    input wire logic [4:0] tx_sa_i,
    input wire logic [4:0] tx_sa_ovr_i,
    input wire logic tx_si_i,
    input wire logic tx_si_ovr_i,
    // Overridden bits heard, newest in bit 0
    output logic [15:0] heard_o
);
logic [1:0] div_q;
// One carrier slot every four clocks, sixteen frames a multiframe
always_ff @(posedge ref_clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        div_q <= 2'h0;
        oh_slot_o <= 1'b0;
        oh_frame_o <= 4'h0;
    end
    else
    begin
        div_q <= div_q + 2'h1;
        oh_slot_o <= (div_q == 2'h3);
        if (oh_slot_o)
            oh_frame_o <= oh_frame_o + 4'h1;
    end
end
// known code, MSB in frame 2
always_comb
begin
    rx_si_o = oh_frame_o[0] ^ div_q[0];
    if (oh_slot_o && oh_frame_o >= 4'h2 && oh_frame_o <= 4'h5)
        rx_si_o = code_i[3'h5 - oh_frame_o[2:0]];
    rx_sa_o = {5{rx_si_o}};
end
always_ff @(posedge ref_clk_i or negedge nrst_i)
begin
    if (!nrst_i)
        heard_o <= 16'h0000;
    else if (oh_slot_o && (|tx_sa_ovr_i || tx_si_ovr_i))
        heard_o <= {heard_o[14:0], |(tx_sa_i & tx_sa_ovr_i) | (tx_si_i & tx_si_ovr_i)};
end
endmodule

// *** sim/escc_code_ctrl_tb.sv ***
// Self-checking testbench of the code controller
`timescale 1ns/1ps
module escc_code_ctrl_tb;
logic ref_clk_i, nrst_i, wr, rd, slot, si_rx, si_tx, si_ovr, cfg_err, alarm, cos, done;
logic mf_en, rsvd;
logic [11:0] addr;
logic [7:0] wdata, rdata;
logic [4:0] sa_sel, sa_rx, sa_tx, sa_ovr;
logic [3:0] frame, code;
logic [1:0] cfg;
logic [2:0] mevt;
logic [15:0] heard;
int err_count, total_checks, cycles, alarm_n, cos_n, m0_n, m1_n, m2_n, i;
escc_code_ctrl dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .oh_slot_i(slot), .oh_frame_i(frame),
    .sa_pos_sel_i(sa_sel), .crc_mf_en_i(mf_en), .crc_multiframe_cfg_i(cfg),
    .rx_sa_i(sa_rx), .rx_si_i(si_rx), .tx_sa_o(sa_tx), .tx_sa_ovr_o(sa_ovr),
    .tx_si_o(si_tx), .tx_si_ovr_o(si_ovr), .rx_status_alarm_o(alarm),
    .cos_evt_o(cos), .match_evt_o(mevt), .tx_done_evt_o(done),
    .rx_code_rsvd_o(rsvd), .cfg_err_o(cfg_err));
escc_remote_model partner (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .code_i(code),
    .oh_slot_o(slot), .oh_frame_o(frame), .rx_sa_o(sa_rx), .rx_si_o(si_rx),
    .tx_sa_i(sa_tx), .tx_sa_ovr_i(sa_ovr), .tx_si_i(si_tx), .tx_si_ovr_i(si_ovr),
    .heard_o(heard));
initial
begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
end
////////////////////////////////////////////////////////////////////////
task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
        err_count++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
endtask
task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
endtask
task automatic wait_mf(input int n);
    repeat (n * 64) @(posedge ref_clk_i);
endtask
task automatic wait_done;
    for (int k = 0; k < 2000; k++)
    begin
        @(posedge ref_clk_i);
        #1;
        if (done === 1'b1)
            break;
    end
endtask
// Event pulse counters and run ceiling
always @(posedge ref_clk_i)
begin
    alarm_n += (alarm === 1'b1);
    cos_n += (cos === 1'b1);
    m0_n += (mevt[0] === 1'b1);
    m1_n += (mevt[1] === 1'b1);
    m2_n += (mevt[2] === 1'b1);
    cycles++;
    if (cycles == 8000)
    begin
        err_count++;
        results;
    end
end
////////////////////////////////////////////////////////////////////////
initial
begin
    {nrst_i, wr, rd, mf_en, cfg, addr, wdata, code} = '0;
    sa_sel = 5'b00100;
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (i = 0; i < 8; i++)
        rd_chk(12'h170 + i, (i == 6) ? 8'h01 : 8'h00);
    wr_reg(12'h172, 8'h04);
    wr_reg(12'h173, 8'h0B);
    wr_reg(12'h175, 8'h0B);
    wr_reg(12'h176, 8'h02);
    rd_chk(12'h173, 8'h0B);
    wr_reg(12'h170, 8'h01);
    rd_chk(12'h170, 8'h00);
    wait_done;
    chk(done, 1'b1);
    chk(heard[11:0], 12'hBBF);
    wr_reg(12'h175, 8'h02);
    wr_reg(12'h176, 8'h01);
    mf_en <= 1'b1;
    wr_reg(12'h170, 8'h81);
    wait_done;
    chk(heard[7:0], 8'h2F);
    chk(cfg_err, 1'b0);
    cfg <= 2'b11;
    wait_mf(1);
    chk(cfg_err, 1'b1);
    cfg <= 2'b00;
    code <= 4'h4;
    alarm_n = 0;
    cos_n = 0;
    m0_n = 0;
    wr_reg(12'h170, 8'h72);
    wait_mf(6);
    rd_chk(12'h171, 8'h04);
    chk(alarm_n, 1);
    chk(cos_n, 1);
    chk(m0_n, 0);
    wait_mf(3);
    chk(m0_n, 1);
    code <= 4'hB;
    alarm_n = 0;
    m1_n = 0;
    wr_reg(12'h170, 8'h10);
    wait_mf(4);
    rd_chk(12'h171, 8'hBB);
    chk(alarm_n, 4);
    chk(m1_n, 4);
    wr_reg(12'h170, 8'h00);
    code <= 4'hF;
    wait_mf(3);
    rd_chk(12'h171, 8'hBB);
    code <= 4'h5;
    m2_n = 0;
    wr_reg(12'h174, 8'h05);
    wr_reg(12'h170, 8'h10);
    wait_mf(2);
    chk(rsvd, 1'b1);
    chk(m2_n, 2);
    wr_reg(12'h176, 8'h05);
    wr_reg(12'h170, 8'hE4);
    wr_reg(12'h170, 8'h08);
    rd_chk(12'h170, 8'h00);
    rd_chk(12'h176, 8'h01);
    rd_chk(12'h172, 8'h00);
    rd_chk(12'h171, 8'h00);
    chk(rsvd, 1'b0);
    results;
end
endmodule
